// ### inc/adcms_pkg.sv
/*
  adcms_pkg: register map, field positions, reset values, mode codes, cycle counts and
  the sequencer state type shared by the converter mode sequencer and its helpers.
  Assumes byte addressing on a 32-bit Avalon-MM slave, one register per aligned word.
*/
package adcms_pkg;

  // register byte offsets
  localparam logic [11:0] ADCMS_OFF_CTRL0  = 12'h03D0;
  localparam logic [11:0] ADCMS_OFF_CTRL2  = 12'h03D4;
  localparam logic [11:0] ADCMS_OFF_CTRL1  = 12'h03D8;
  localparam logic [11:0] ADCMS_OFF_STATUS = 12'h03DC;
  localparam logic [11:0] ADCMS_OFF_RES0   = 12'h03A0;

  // control 0 fields: channel select, mode, start flag, trigger select
  localparam int ADCMS_C0_CHAN_LSB = 0;
  localparam int ADCMS_C0_MODE_LSB = 3;
  localparam int ADCMS_C0_START    = 6;
  localparam int ADCMS_C0_EXTTRIG  = 7;
  // control 1 fields: sweep select, resolution, converter clock divide
  localparam int ADCMS_C1_SWEEP_LSB = 0;
  localparam int ADCMS_C1_RES10     = 2;
  localparam int ADCMS_C1_DIV_LSB   = 3;
  // control 2 field: sample and hold enable
  localparam int ADCMS_C2_SH        = 0;
  // status fields
  localparam int ADCMS_ST_BUSY      = 0;
  localparam int ADCMS_ST_ARMED     = 1;
  localparam int ADCMS_ST_CHAN_LSB  = 2;

  // reset values
  localparam logic [7:0] ADCMS_RST_CTRL0 = 8'h00;
  localparam logic [7:0] ADCMS_RST_CTRL1 = 8'h00;
  localparam logic       ADCMS_RST_SH    = 1'b0;

  // operating modes
  localparam logic [2:0] ADCMS_MODE_ONESHOT = 3'h0;
  localparam logic [2:0] ADCMS_MODE_REPEAT  = 3'h1;
  localparam logic [2:0] ADCMS_MODE_SWEEP1  = 3'h2;
  localparam logic [2:0] ADCMS_MODE_RSWEEP0 = 3'h3;
  localparam logic [2:0] ADCMS_MODE_RSWEEP1 = 3'h4;

  // converter clock cycles per channel
  localparam logic [5:0] ADCMS_CYC_SH_8    = 6'd28;
  localparam logic [5:0] ADCMS_CYC_SH_10   = 6'd33;
  localparam logic [5:0] ADCMS_CYC_NOSH_8  = 6'd49;
  localparam logic [5:0] ADCMS_CYC_NOSH_10 = 6'd59;

  typedef enum logic [2:0] {
    ADCMS_IDLE  = 3'b001,
    ADCMS_ARMED = 3'b010,
    ADCMS_CONV  = 3'b100
  } adcms_state_e;

endpackage : adcms_pkg

// ### rtl/adcms_sync.sv
/*
  adcms_sync: two-flop synchroniser for a bus from outside the clock domain, with a
  third stage giving a high-to-low edge pulse on bit 0.
  Assumes multi-bit inputs are held stable by their source while they are sampled.
*/
`timescale 1ns/1ns
module adcms_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic              fall
);

  logic [W-1:0] meta;
  logic         prev;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '0;
      q    <= '0;
      prev <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
      prev <= q[0];
    end
  end

  assign fall = prev & ~q[0];

endmodule : adcms_sync

// ### rtl/adcms_div.sv
/*
  adcms_div: converter clock enable, one pulse every 1, 2 or 4 system clocks.
  Assumes the divide select changes only while the converter is idle.
*/
`timescale 1ns/1ns
module adcms_div (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [1:0] div_sel,
  output logic            ce
);

  logic [1:0] cnt;
  wire  [1:0] term = (div_sel == 2'h0) ? 2'h0 : ((div_sel == 2'h1) ? 2'h1 : 2'h3);

  // terminal count restarts the divider and fires the enable
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 2'h0;
      ce  <= 1'b0;
    end else if (cnt >= term) begin
      cnt <= 2'h0;
      ce  <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
      ce  <= 1'b0;
    end
  end

endmodule : adcms_div

// ### rtl/adcms_top.sv
/*
  adcms_top: mode sequencer for an eight-channel successive approximation converter:
  start and stop control, channel sequencing in five modes, per-channel result storage,
  conversion timing and the completion request. Registers sit on an Avalon-MM slave.
  Assumes an analog front end that samples the channel on SAMPLE_CH while CONV_ACTIVE is
  high and presents a stable 10-bit code on CONV_DATA by the end of each conversion.
*/
// Behaviour
// - writing one to the start flag begins conversion in every mode
// - one-shot mode converts the selected channel exactly once
// - the selected channel is one of inputs 0 to 7
// - one-shot and single sweep clear the start flag at end, unless externally triggered
// - one-shot and single sweep raise a completion request at end
// - writing zero to the start flag stops conversion at once
// - repeat mode converts the selected channel until stopped, no request
// - single sweep converts the 2, 4, 6 or 8 channel group once
// - repeat sweep 0 sweeps the group until stopped, no request
// - repeat sweep 1 converts emphasised channels before each other channel, repeatedly
// - repeat sweep 1 emphasises 1, 2, 3 or 4 channels from channel 0
// - each result goes to the register of the converted channel
// - result registers read any time with the latest value
// - bit 0 of control register 2 at 03D4 enables sample and hold
// - with sample and hold a channel takes 28 or 33 converter clocks
// - external trigger starts on a falling edge while start is one, retriggerable
// - without sample and hold a channel takes 49 or 59 converter clocks
// - 10-bit results split low byte and top two bits; 8-bit writes low byte only
`timescale 1ns/1ns
module adcms_top
  import adcms_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic [11:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        EXTERNAL_CONVERSION_TRIGGER,
  input  wire logic [9:0]  CONV_DATA,
  output logic      [2:0]  SAMPLE_CH,
  output logic             CONV_ACTIVE,
  output logic             SH_ENABLE,
  output logic             RES10_OUT,
  output logic             CONV_DONE_IRQ
);

  // control state
  logic [2:0]   chan_sel;
  logic [2:0]   mode;
  logic         start_flag;
  logic         ext_sel;
  logic [1:0]   sweep_sel;
  logic         res10;
  logic [1:0]   div_sel;
  adcms_state_e state;
  logic [2:0]   ch;
  logic [2:0]   other_ch;
  logic         in_emph;
  logic [5:0]   cnt;
  logic [7:0]   res_lo [8];
  logic [1:0]   res_hi [8];

  // helpers
  logic       ce;
  logic [9:0] data_s;
  logic       trig_s;
  logic       trig_fall;

  adcms_div u_div (
    .clk     (CLK_SYS),
    .srst    (SRST),
    .div_sel (div_sel),
    .ce      (ce)
  );

  // trigger pin and front-end code both come from outside the clock domain
  adcms_sync #(.W(1)) u_trig_sync (
    .clk  (CLK_SYS),
    .srst (SRST),
    .d    (EXTERNAL_CONVERSION_TRIGGER),
    .q    (trig_s),
    .fall (trig_fall)
  );

  adcms_sync #(.W(10)) u_data_sync (
    .clk  (CLK_SYS),
    .srst (SRST),
    .d    (CONV_DATA),
    .q    (data_s),
    .fall ()
  );

  // bus decode: one wait cycle, then the access is taken
  wire       req      = AVS_READ | AVS_WRITE;
  wire       take     = req & ~AVS_WAITREQUEST;
  wire       wr_take  = AVS_WRITE & take & AVS_BYTEENABLE[0];
  wire       hit_c0   = (AVS_ADDRESS == ADCMS_OFF_CTRL0);
  wire       hit_c1   = (AVS_ADDRESS == ADCMS_OFF_CTRL1);
  wire       hit_c2   = (AVS_ADDRESS == ADCMS_OFF_CTRL2);
  wire       hit_st   = (AVS_ADDRESS == ADCMS_OFF_STATUS);
  wire       hit_res  = (AVS_ADDRESS[11:5] == ADCMS_OFF_RES0[11:5]) & (AVS_ADDRESS[1:0] == 2'h0);
  wire [2:0] res_idx  = AVS_ADDRESS[4:2];
  wire       wr_c0    = wr_take & hit_c0;
  wire       wr_c1    = wr_take & hit_c1;
  wire       wr_c2    = wr_take & hit_c2;
  wire       sw_start = wr_c0 & AVS_WRITEDATA[ADCMS_C0_START];
  wire       sw_stop  = wr_c0 & ~AVS_WRITEDATA[ADCMS_C0_START];

  // mode groups
  wire is_single = (mode == ADCMS_MODE_ONESHOT) | (mode == ADCMS_MODE_REPEAT);
  wire is_once   = (mode == ADCMS_MODE_ONESHOT) | (mode == ADCMS_MODE_SWEEP1);
  wire is_rs1    = (mode == ADCMS_MODE_RSWEEP1);

  wire [5:0] conv_len = SH_ENABLE ? (res10 ? ADCMS_CYC_SH_10 : ADCMS_CYC_SH_8)
                                  : (res10 ? ADCMS_CYC_NOSH_10 : ADCMS_CYC_NOSH_8);
  wire       in_conv  = (state == ADCMS_CONV);
  wire       finish   = in_conv & ce & (cnt == 6'(conv_len - 6'd1));

  // sweep group of 2, 4, 6 or 8 from channel 0
  wire [2:0] sweep_last = {sweep_sel, 1'b1};
  // emphasised group of 1 to 4 channels
  wire [2:0] emph_last  = {1'b0, sweep_sel};
  wire [2:0] emph_n     = 3'({1'b0, sweep_sel} + 3'd1);

  // single modes use the selected input; sweeps open at channel 0
  wire [2:0] first_ch = is_single ? chan_sel : 3'h0;

  // emphasised channels, then one other channel, other pointer wraps
  wire [2:0] other_nx = (other_ch == 3'h7) ? emph_n : 3'(other_ch + 3'd1);
  wire [2:0] rs1_ch   = in_emph ? ((ch == emph_last) ? other_ch : 3'(ch + 3'd1)) : 3'h0;
  wire       rs1_emph = in_emph ? (ch != emph_last) : 1'b1;
  wire [2:0] rs1_oth  = in_emph ? other_ch : other_nx;

  // ascending order with wrap to channel 0
  wire [2:0] sweep_nx = (ch == sweep_last) ? 3'h0 : 3'(ch + 3'd1);
  wire [2:0] next_ch  = is_single ? ch : (is_rs1 ? rs1_ch : sweep_nx);

  // one-shot ends after one channel; single sweep after the last
  wire run_end    = (mode == ADCMS_MODE_ONESHOT) | ((mode == ADCMS_MODE_SWEEP1) & (ch == sweep_last));
  wire run_done   = finish & run_end & is_once;
  // falling edge while the flag is one starts or restarts a run
  wire ext_go     = ext_sel & start_flag & trig_fall & ~wr_c0 & (state != ADCMS_IDLE);
  wire begin_run  = (sw_start & ~AVS_WRITEDATA[ADCMS_C0_EXTTRIG]) | ext_go;

  // next state
  wire adcms_state_e next_state =
      sw_stop  ? ADCMS_IDLE :
      sw_start ? (AVS_WRITEDATA[ADCMS_C0_EXTTRIG] ? ADCMS_ARMED : ADCMS_CONV) :
      ext_go   ? ADCMS_CONV :
      run_done ? (ext_sel ? ADCMS_ARMED : ADCMS_IDLE) :
      state;

  // hardware clears the flag at end unless externally triggered
  wire hw_clear = run_done & ~ext_sel;

  // bus handshake and read data; the read word is latched at the wait cycle
  wire [31:0] rd_c0  = {24'h0, ext_sel, start_flag, mode, chan_sel};
  wire [31:0] rd_c1  = {27'h0, div_sel, res10, sweep_sel};
  wire [31:0] rd_c2  = {31'h0, SH_ENABLE};
  wire [31:0] rd_st  = {26'h0, ch, (state == ADCMS_ARMED), in_conv};
  // results readable at any time, latest value
  wire [31:0] rd_res = {22'h0, res_hi[res_idx], res_lo[res_idx]};
  wire [31:0] rd_word = hit_c0  ? rd_c0 :
                        hit_c1  ? rd_c1 :
                        hit_c2  ? rd_c2 :
                        hit_st  ? rd_st :
                        hit_res ? rd_res : 32'h0000_0000;

  // waitrequest drops for one cycle per request
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
      if (AVS_READ & AVS_WAITREQUEST) begin
        AVS_READDATA <= rd_word;
      end
    end
  end

  // control registers; a software write of the flag wins over the hardware clear
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      {ext_sel, start_flag, mode, chan_sel} <= ADCMS_RST_CTRL0;
      {div_sel, res10, sweep_sel}           <= ADCMS_RST_CTRL1[4:0];
      SH_ENABLE                             <= ADCMS_RST_SH;
    end else begin
      if (wr_c0) begin
        {ext_sel, start_flag, mode, chan_sel} <= AVS_WRITEDATA[7:0];
      end else if (hw_clear) begin
        start_flag <= 1'b0;
      end
      if (wr_c1) begin
        {div_sel, res10, sweep_sel} <= AVS_WRITEDATA[4:0];
      end
      // software sets it before starting; taken as written
      if (wr_c2) begin
        SH_ENABLE <= AVS_WRITEDATA[ADCMS_C2_SH];
      end
    end
  end

  // sequencer state and channel pointers
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state    <= ADCMS_IDLE;
      ch       <= 3'h0;
      other_ch <= 3'h1;
      in_emph  <= 1'b1;
      cnt      <= 6'h00;
    end else begin
      state <= next_state;
      if (begin_run) begin
        ch       <= AVS_WRITEDATA[ADCMS_C0_START] & wr_c0 ?
                    ((AVS_WRITEDATA[5:3] == ADCMS_MODE_ONESHOT) | (AVS_WRITEDATA[5:3] == ADCMS_MODE_REPEAT) ?
                     AVS_WRITEDATA[2:0] : 3'h0) : first_ch;
        other_ch <= emph_n;
        in_emph  <= 1'b1;
        cnt      <= 6'h00;
      end else if (finish) begin
        // repeat sweep 0 wraps without end
        ch       <= next_ch;
        other_ch <= rs1_oth;
        in_emph  <= rs1_emph;
        cnt      <= 6'h00;
      end else if (in_conv & ce) begin
        cnt <= 6'(cnt + 6'd1);
      end
    end
  end

  // front-end controls follow the sequencer
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      SAMPLE_CH     <= 3'h0;
      CONV_ACTIVE   <= 1'b0;
      RES10_OUT     <= 1'b0;
      CONV_DONE_IRQ <= 1'b0;
    end else begin
      SAMPLE_CH     <= ch;
      CONV_ACTIVE   <= (next_state == ADCMS_CONV);
      RES10_OUT     <= res10;
      // completion request, only for one-shot and single sweep
      CONV_DONE_IRQ <= run_done;
    end
  end

  // per-channel result registers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_res
      // write only the register of the converted channel
      wire hit = finish & (ch == 3'(gi));
      always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
          res_lo[gi] <= 8'h00;
          res_hi[gi] <= 2'h0;
        end else if (hit) begin
          // 10-bit splits across two bytes; 8-bit keeps the upper byte
          res_lo[gi] <= res10 ? data_s[7:0] : data_s[9:2];
          if (res10) begin
            res_hi[gi] <= data_s[9:8];
          end
        end
      end
    end
  endgenerate

endmodule : adcms_top

// ### dv/adcms_checker.sv
/*
  adcms_checker: port assertions for the mode sequencer.
  Assumes one clock, CLK_SYS, and synchronous SRST.
*/
`timescale 1ns/1ns
module adcms_checker
  import adcms_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        SRST,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        EXTERNAL_CONVERSION_TRIGGER,
  input wire logic [9:0]  CONV_DATA,
  input wire logic [2:0]  SAMPLE_CH,
  input wire logic        CONV_ACTIVE,
  input wire logic        SH_ENABLE,
  input wire logic        RES10_OUT,
  input wire logic        CONV_DONE_IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  // accepted lane-0 writes per target
  wire       wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  wire       c0_wr = wr_ok && AVS_ADDRESS == ADCMS_OFF_CTRL0;
  wire       c1_wr = wr_ok && AVS_ADDRESS == ADCMS_OFF_CTRL1;
  wire       c2_wr = wr_ok && AVS_ADDRESS == ADCMS_OFF_CTRL2;
  wire [7:0] wd    = AVS_WRITEDATA[7:0];

  // length of last run; saturates so long sweeps never wrap
  logic [7:0] run_cnt;
  logic [7:0] last_len;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      run_cnt  <= 8'h00;
      last_len <= 8'h00;
    end else if (CONV_ACTIVE) begin
      run_cnt <= (run_cnt == 8'hFF) ? run_cnt : run_cnt + 8'h01;
    end else if (run_cnt != 8'h00) begin
      last_len <= run_cnt;
      run_cnt  <= 8'h00;
    end
  end

  wait_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered");
  wait_one_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low too long");
  start_write_a: assert property (c0_wr && wd[6] && !wd[7] |-> ##[1:2] CONV_ACTIVE)
    else $error("start write did not start");
  stop_write_a: assert property (c0_wr && !wd[6] |-> ##[1:2] !CONV_ACTIVE)
    else $error("stop write did not stop");
  sh_follow_a: assert property (c2_wr |-> ##2 SH_ENABLE == $past(wd[0], 2))
    else $error("hold enable wrong");
  res_follow_a: assert property (c1_wr |-> ##2 RES10_OUT == $past(wd[2], 2))
    else $error("resolution pin wrong");
  irq_pulse_a: assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ)
    else $error("irq longer than a cycle");
  irq_end_a: assert property ($rose(CONV_DONE_IRQ) |-> !CONV_ACTIVE && $past(CONV_ACTIVE, 2))
    else $error("irq not at run end");
  conv_len_a: assert property (CONV_DONE_IRQ |-> ##2 last_len >= 8'h1B)
    else $error("run too short");

  irq_c:  cover property (CONV_DONE_IRQ);
  run_c:  cover property ($rose(CONV_ACTIVE));
  stop_c: cover property (c0_wr && !wd[6] && CONV_ACTIVE);
endmodule : adcms_checker

bind adcms_top adcms_checker chk (.CLK_SYS, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .EXTERNAL_CONVERSION_TRIGGER,
  .CONV_DATA, .SAMPLE_CH, .CONV_ACTIVE, .SH_ENABLE, .RES10_OUT, .CONV_DONE_IRQ);

// ### dv/adcms_front.sv
/*
  adcms_front: analog front end and trigger pin model.
  Assumes codes are sampled only while a run is active.
*/
`timescale 1ns/1ns
module adcms_front (
  input  wire logic       clk,
  input  wire logic [2:0] sample_ch,
  input  wire logic       active,
  output logic      [9:0] code,
  output logic            trig
);
  initial begin
    code = 10'h000;
    trig = 1'b1;
  end
  // channel-tagged code; toggles when idle so stale data never passes
  always @(posedge clk) begin
    code <= active ? {sample_ch, 4'hA, sample_ch} : ~code;
  end
  // trigger idles high, pulled low briefly
  task fire;
    @(posedge clk);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
    trig <= 1'b1;
  endtask : fire
endmodule : adcms_front

// ### dv/test_adc_mode_sequencer.sv
/*
  test_adc_mode_sequencer: self-checking bench for the mode sequencer.
  Assumes adcms_front on the analog side and the bound checker.
*/
`timescale 1ns/1ns
module test_adc_mode_sequencer;
  import adcms_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic        waitreq;
  logic        trig;
  logic [9:0]  conv_data;
  logic [2:0]  sample_ch;
  logic        active;
  logic        sh;
  logic        res10;
  logic        irq;
  int          fails = 0;
  int          comparisons = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  adcms_top dut (.CLK_SYS(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .EXTERNAL_CONVERSION_TRIGGER(trig), .CONV_DATA(conv_data), .SAMPLE_CH(sample_ch),
    .CONV_ACTIVE(active), .SH_ENABLE(sh), .RES10_OUT(res10), .CONV_DONE_IRQ(irq));
  adcms_front front (.clk(clk), .sample_ch(sample_ch), .active(active), .code(conv_data), .trig(trig));

  function automatic logic [9:0] code10(input int c);
    return {c[2:0], 4'hA, c[2:0]};
  endfunction : code10
  function automatic logic [11:0] res(input int c);
    return 12'(ADCMS_OFF_RES0 + 4 * c);
  endfunction : res

  task conclude;
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // request held until waitrequest sampled low
  task bus(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 100) begin
      fails++;
      conclude();
    end
  endtask : bus
  task wrr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wrr
  task rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(nm, q, e);
  endtask : rc
  task wirq(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fails++;
      conclude();
    end
  endtask : wirq

  task s_reset;
    rc("ctrl0", ADCMS_OFF_CTRL0, 0);
    rc("ctrl2", ADCMS_OFF_CTRL2, 0);
    rc("unmapped", 12'h100, 0);
    wrr(ADCMS_OFF_RES0, 8'hFF);
    rc("result ro", ADCMS_OFF_RES0, 0);
  endtask : s_reset
  task s_oneshot;
    int n;
    for (int c = 0; c < 8; c++) begin
      wrr(ADCMS_OFF_CTRL0, 8'(8'h40 + c));
      wirq(n);
      chk("cycles", 32'(n >= 49 && n <= 53), 1);
      rc("start", ADCMS_OFF_CTRL0, c);
      rc("res8", res(c), 32'(code10(c) >> 2));
    end
    // hold choice fixed before the next start
    wrr(ADCMS_OFF_CTRL2, 8'h01);
    wrr(ADCMS_OFF_CTRL1, 8'h04);
    chk("sh pin", sh, 1);
    wrr(ADCMS_OFF_CTRL0, 8'h45);
    wirq(n);
    chk("sh cycles", 32'(n >= 33 && n <= 37), 1);
    rc("res10", res(5), code10(5));
  endtask : s_oneshot
  task s_sweep;
    int n;
    wrr(ADCMS_OFF_CTRL1, 8'h06);
    wrr(ADCMS_OFF_CTRL0, 8'h50);
    wirq(n);
    chk("sweep cycles", 32'(n >= 198 && n <= 206), 1);
    rc("start", ADCMS_OFF_CTRL0, 8'h10);
    for (int c = 0; c < 8; c++)
      rc("sweep res", res(c), c < 6 ? code10(c) : 32'(code10(c) >> 2));
  endtask : s_sweep
  task s_repeat;
    logic [31:0] q;
    logic        hit;
    hit = 1'b0;
    wrr(ADCMS_OFF_CTRL0, 8'h4B);
    repeat (200) begin
      @(posedge clk);
      hit = hit | (irq === 1'b1);
    end
    chk("repeat irq", hit, 0);
    rc("status", ADCMS_OFF_STATUS, 32'h0000_000D);
    rc("live res", res(3), code10(3));
    wrr(ADCMS_OFF_CTRL0, 8'h0B);
    bus(ADCMS_OFF_STATUS, 1'b0, 8'h00, q);
    chk("busy", q[0], 0);
  endtask : s_repeat
  // channel order over nine successive conversions
  task scan(input logic [7:0] c0, input logic [35:0] e);
    int          n;
    logic [2:0]  last;
    n = 0;
    wrr(ADCMS_OFF_CTRL0, c0);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      while (i > 0 && sample_ch === last && n < 3000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 3000) begin
        fails++;
        conclude();
      end
      chk("channel", sample_ch, e[34-4*i -: 3]);
      last = sample_ch;
    end
    wrr(ADCMS_OFF_CTRL0, 8'h00);
  endtask : scan
  task s_ext;
    logic [31:0] q;
    int          n;
    wrr(ADCMS_OFF_CTRL1, 8'h04);
    wrr(ADCMS_OFF_CTRL0, 8'hC2);
    bus(ADCMS_OFF_STATUS, 1'b0, 8'h00, q);
    chk("armed", q[1:0], 2'b10);
    repeat (2) begin
      front.fire();
      wirq(n);
      chk("trig cycles", 32'(n >= 26 && n <= 40), 1);
      rc("start kept", ADCMS_OFF_CTRL0, 8'hC2);
    end
    wrr(ADCMS_OFF_CTRL0, 8'h00);
  endtask : s_ext

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    s_reset();
    s_oneshot();
    s_sweep();
    s_repeat();
    wrr(ADCMS_OFF_CTRL1, 8'h04);
    scan(8'h58, 36'h010_101_010);
    wrr(ADCMS_OFF_CTRL1, 8'h05);
    scan(8'h60, 36'h012_013_014);
    s_ext();
    conclude();
  end
endmodule : test_adc_mode_sequencer
